/* File: common/csbu_pkg.sv */
/*
  Shared constants and types of the compare, skip and branch unit.
  Assumes the core numbers status flags in the usual order, carry in bit 0.
*/
package csbu_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int OFFSET_W = 7;
  localparam int PC_W = 16;
  localparam int CNT_W = 2;

  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_H = 3'h5;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;

  // Program counter steps
  localparam logic [1:0] STEP_NEXT = 2'h1;
  localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
  localparam logic [1:0] STEP_SKIP_TWO = 2'h3;

  // Cycle counts
  localparam logic [CNT_W-1:0] CYC_ONE = 2'h1;
  localparam logic [CNT_W-1:0] CYC_TWO = 2'h2;
  localparam logic [CNT_W-1:0] CYC_THREE = 2'h3;

  typedef enum logic [3:0] {
    compare_immediate = 4'h0,
    compare_with_carry_in = 4'h1,
    skip_reg_bit_clear = 4'h2,
    skip_reg_bit_set = 4'h3,
    skip_io_bit_clear = 4'h4,
    skip_io_bit_set = 4'h5,
    branch_flag_set = 4'h6,
    branch_flag_clear = 4'h7,
    branch_equal = 4'h8,
    branch_not_equal = 4'h9,
    branch_carry_one = 4'ha,
    branch_carry_zero = 4'hb,
    branch_same_or_higher = 4'hc,
    branch_lower = 4'hd,
    branch_negative = 4'he,
    branch_positive = 4'hf
  } csbu_op_t;

  typedef enum logic [0:0] {
    CSBU_IDLE = 1'b0,
    CSBU_BUSY = 1'b1
  } csbu_state_t;

endpackage

/* File: rtl/csbu_cmp_flags.sv */
/*
  Flag arithmetic of the two compares: subtracts without keeping the result.
  Assumes operands are stable in the cycle the caller samples the flags.
*/
`timescale 1ns/10ps
module csbu_cmp_flags
  import csbu_pkg::*;
#(
  parameter int W = DATA_W
) (
  // Operands
  input wire logic [W-1:0] lhs,
  input wire logic [W-1:0] rhs,
  input wire logic with_carry,
  input wire logic carry_in,
  input wire logic zero_in,
  // Flags
  output logic half_borrow,
  output logic overflow,
  output logic negative,
  output logic zero,
  output logic borrow
);

  logic [W:0] diff;
  logic [4:0] low_diff;
  logic cin;

  assign cin = with_carry & carry_in;
  assign diff = {1'b0, lhs} - {1'b0, rhs} - {{W{1'b0}}, cin};
  assign low_diff = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};

  assign borrow = diff[W];
  assign half_borrow = low_diff[4];
  assign negative = diff[W-1];
  assign overflow = (lhs[W-1] & ~rhs[W-1] & ~diff[W-1]) |
                    (~lhs[W-1] & rhs[W-1] & diff[W-1]);
  // With carry in, a zero result only keeps an earlier zero
  assign zero = (diff[W-1:0] == {W{1'b0}}) & (~with_carry | zero_in);

endmodule

/* File: rtl/csbu_core.sv */
/*
  Execution of compares, conditional skips and relative branches.
  Assumes the core presents one instruction with its operands for one cycle on
  cmd_valid while ready, and holds the next instruction's length beside it.
*/
`timescale 1ns/10ps
module csbu_core
  import csbu_pkg::*;
#(
  parameter int PCW = PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Instruction
  input wire logic cmd_valid,
  input wire csbu_pkg::csbu_op_t cmd_op,
  input wire logic [csbu_pkg::DATA_W-1:0] reg_a,
  input wire logic [csbu_pkg::DATA_W-1:0] reg_b,
  input wire logic [csbu_pkg::DATA_W-1:0] imm,
  input wire logic [csbu_pkg::DATA_W-1:0] io_value,
  input wire logic [csbu_pkg::BIT_SEL_W-1:0] bit_sel,
  input wire logic [csbu_pkg::OFFSET_W-1:0] offset,
  input wire logic next_two_words,
  // Program counter and status in
  input wire logic [PCW-1:0] pc_in,
  input wire logic [csbu_pkg::DATA_W-1:0] status_in,
  // Results
  output logic ready_ff,
  output logic done_ff,
  output logic pc_load_ff,
  output logic [PCW-1:0] pc_next_ff,
  output logic flags_we_ff,
  output logic [csbu_pkg::DATA_W-1:0] status_ff
);
  import csbu_pkg::*;

  // Branch flag index and the level that takes the branch
  function automatic logic [3:0] branch_cond(input csbu_op_t op,
                                             input logic [2:0] sel);
    logic [3:0] r;
    r = {1'b1, sel};
    case (op)
      branch_flag_set: r = {1'b1, sel};
      branch_flag_clear: r = {1'b0, sel};
      branch_equal: r = {1'b1, FLAG_Z};
      branch_not_equal: r = {1'b0, FLAG_Z};
      branch_carry_one: r = {1'b1, FLAG_C};
      branch_lower: r = {1'b1, FLAG_C};
      branch_carry_zero: r = {1'b0, FLAG_C};
      branch_same_or_higher: r = {1'b0, FLAG_C};
      branch_negative: r = {1'b1, FLAG_N};
      branch_positive: r = {1'b0, FLAG_N};
      default: r = {1'b1, sel};
    endcase
    return r;
  endfunction

  function automatic logic is_branch(input csbu_op_t op);
    return op >= branch_flag_set;
  endfunction

  function automatic logic is_compare(input csbu_op_t op);
    return (op == compare_immediate) || (op == compare_with_carry_in);
  endfunction

  function automatic logic [PCW-1:0] step(input logic [1:0] s);
    return {{(PCW-2){1'b0}}, s};
  endfunction

  csbu_state_t state_ff;
  csbu_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic accept;
  logic [CNT_W-1:0] nxt_cycles;
  logic [PCW-1:0] nxt_pc;
  logic nxt_load;
  logic tested_bit;
  logic skip_take;
  logic branch_take;
  logic [3:0] cond;
  logic is_skip;
  logic [DATA_W-1:0] cmp_rhs;
  logic f_h;
  logic f_v;
  logic f_n;
  logic f_z;
  logic f_c;
  logic [DATA_W-1:0] nxt_status;
  logic [PCW-1:0] branch_target;

  assign accept = ce & cmd_valid & (state_ff == CSBU_IDLE);

  assign cmp_rhs = (cmd_op == compare_with_carry_in) ? reg_b : imm;

  csbu_cmp_flags #(
    .W(DATA_W)
  ) u_flags (
    .lhs(reg_a),
    .rhs(cmp_rhs),
    .with_carry(cmd_op == compare_with_carry_in),
    .carry_in(status_in[FLAG_C]),
    .zero_in(status_in[FLAG_Z]),
    .half_borrow(f_h),
    .overflow(f_v),
    .negative(f_n),
    .zero(f_z),
    .borrow(f_c)
  );

  // Only the five compare flags change; the rest pass through
  always_comb begin
    nxt_status = status_in;
    nxt_status[FLAG_H] = f_h;
    nxt_status[FLAG_V] = f_v;
    nxt_status[FLAG_N] = f_n;
    nxt_status[FLAG_Z] = f_z;
    nxt_status[FLAG_C] = f_c;
  end

  // Skip decision
  always_comb begin
    tested_bit = 1'b0;
    skip_take = 1'b0;
    is_skip = 1'b0;
    case (cmd_op)
      skip_reg_bit_clear: begin
        is_skip = 1'b1;
        tested_bit = reg_b[bit_sel];
        skip_take = ~tested_bit;
      end
      skip_reg_bit_set: begin
        is_skip = 1'b1;
        tested_bit = reg_b[bit_sel];
        skip_take = tested_bit;
      end
      skip_io_bit_clear: begin
        is_skip = 1'b1;
        tested_bit = io_value[bit_sel];
        skip_take = ~tested_bit;
      end
      skip_io_bit_set: begin
        is_skip = 1'b1;
        tested_bit = io_value[bit_sel];
        skip_take = tested_bit;
      end
      default: begin
        is_skip = 1'b0;
        tested_bit = 1'b0;
        skip_take = 1'b0;
      end
    endcase
  end

  assign cond = branch_cond(cmd_op, bit_sel);
  assign branch_take = is_branch(cmd_op) & (status_in[cond[2:0]] == cond[3]);

  // Signed offset, then one more word
  assign branch_target = pc_in +
                         {{(PCW-OFFSET_W){offset[OFFSET_W-1]}}, offset} +
                         step(STEP_NEXT);

  // Target and length of the instruction
  always_comb begin
    nxt_pc = pc_in + step(STEP_NEXT);
    nxt_load = 1'b0;
    nxt_cycles = CYC_ONE;
    if (is_skip && skip_take) begin
      nxt_load = 1'b1;
      if (next_two_words) begin
        nxt_pc = pc_in + step(STEP_SKIP_TWO);
        nxt_cycles = CYC_THREE;
      end else begin
        nxt_pc = pc_in + step(STEP_SKIP_ONE);
        nxt_cycles = CYC_TWO;
      end
    end else if (branch_take) begin
      nxt_load = 1'b1;
      nxt_pc = branch_target;
      nxt_cycles = CYC_TWO;
    end
  end

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CSBU_IDLE: begin
        if (accept && (nxt_cycles != CYC_ONE)) begin
          nxt_state = CSBU_BUSY;
        end
      end
      CSBU_BUSY: begin
        if (cnt_ff == CYC_ONE) begin
          nxt_state = CSBU_IDLE;
        end
      end
      default: nxt_state = CSBU_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= CSBU_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Cycles still owed after the first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (accept) begin
        cnt_ff <= nxt_cycles - CYC_ONE;
      end else if (state_ff == CSBU_BUSY) begin
        cnt_ff <= cnt_ff - CYC_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_ff <= 1'b1;
    end else if (ce) begin
      ready_ff <= (nxt_state == CSBU_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= (accept && (nxt_cycles == CYC_ONE)) ||
                 ((state_ff == CSBU_BUSY) && (cnt_ff == CYC_ONE));
    end
  end

  // Program counter result held until the next instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_next_ff <= PC_RST;
      pc_load_ff <= 1'b0;
    end else if (ce && accept) begin
      pc_next_ff <= nxt_pc;
      pc_load_ff <= nxt_load;
    end
  end

  // Skips and branches never write flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= STATUS_RST;
      flags_we_ff <= 1'b0;
    end else if (ce) begin
      flags_we_ff <= accept & is_compare(cmd_op);
      if (accept) begin
        status_ff <= is_compare(cmd_op) ? nxt_status : status_in;
      end
    end
  end

endmodule

/* File: sim/csbu_core_properties.sv */
/* Port assertions for the compare, skip and branch unit.
   Bound to csbu_core; checks pause while ce is low. */
`timescale 1ns/10ps
module csbu_core_properties
  import csbu_pkg::*;
#(parameter int PCW = PC_W) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire csbu_pkg::csbu_op_t cmd_op,
  // Operands
  input wire logic [csbu_pkg::DATA_W-1:0] reg_a,
  input wire logic [csbu_pkg::DATA_W-1:0] reg_b,
  input wire logic [csbu_pkg::DATA_W-1:0] imm,
  input wire logic [csbu_pkg::DATA_W-1:0] io_value,
  input wire logic [csbu_pkg::BIT_SEL_W-1:0] bit_sel,
  input wire logic [csbu_pkg::OFFSET_W-1:0] offset,
  input wire logic next_two_words,
  input wire logic [PCW-1:0] pc_in,
  input wire logic [csbu_pkg::DATA_W-1:0] status_in,
  // Results
  input wire logic ready_ff,
  input wire logic done_ff,
  input wire logic pc_load_ff,
  input wire logic [PCW-1:0] pc_next_ff,
  input wire logic flags_we_ff,
  input wire logic [csbu_pkg::DATA_W-1:0] status_ff
);
  logic acc, cin, zin;
  logic [PCW-1:0] tgt;
  assign acc = ce && cmd_valid && ready_ff;
  assign cin = status_in[FLAG_C];
  assign zin = status_in[FLAG_Z];
  assign tgt = pc_in + {{(PCW-OFFSET_W){offset[OFFSET_W-1]}}, offset} + 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  sequence s_two; !done_ff ##1 done_ff; endsequence
  sequence s_three; !done_ff ##1 !done_ff ##1 done_ff; endsequence
  property p_cmp;
    acc && cmd_op == compare_immediate |=> done_ff && flags_we_ff && !pc_load_ff
      && pc_next_ff == $past(pc_in) + 1'b1 && status_ff[FLAG_Z] == ($past(reg_a) == $past(imm))
      && status_ff[FLAG_C] == ($past(reg_a) < $past(imm));
  endproperty
  property p_skip_flags;
    acc && cmd_op inside {skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear,
      skip_io_bit_set} |=> status_ff == $past(status_in) && !flags_we_ff;
  endproperty
  property p_skip_two;
    acc && cmd_op == skip_reg_bit_clear && !reg_b[bit_sel] && !next_two_words
      |=> (pc_load_ff && pc_next_ff == $past(pc_in) + 2'h2) ##0 s_two;
  endproperty
  property p_skip_three;
    acc && cmd_op == skip_io_bit_set && io_value[bit_sel] && next_two_words
      |=> (pc_load_ff && pc_next_ff == $past(pc_in) + 2'h3) ##0 s_three;
  endproperty
  property p_skip_miss;
    acc && cmd_op == skip_reg_bit_set && !reg_b[bit_sel] |=> done_ff && !pc_load_ff;
  endproperty
  property p_io_clear;
    acc && cmd_op == skip_io_bit_clear && !io_value[bit_sel] |=> pc_load_ff && !done_ff;
  endproperty
  property p_br_set;
    acc && cmd_op == branch_flag_set && status_in[bit_sel]
      |=> (pc_load_ff && pc_next_ff == $past(tgt)) ##0 s_two;
  endproperty
  property p_br_clr;
    acc && cmd_op == branch_flag_clear && status_in[bit_sel]
      |=> done_ff && !pc_load_ff && pc_next_ff == $past(pc_in) + 1'b1;
  endproperty
  property p_br_c;
    acc && cmd_op inside {branch_carry_zero, branch_same_or_higher} |=> pc_load_ff == !$past(cin);
  endproperty
  property p_br_eq;
    acc && cmd_op == branch_equal |=> pc_load_ff == $past(zin);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare result wrong");
  a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");
  a_skip_two: assert property (p_skip_two) else $error("short skip wrong");
  a_skip_three: assert property (p_skip_three) else $error("long skip wrong");
  a_skip_miss: assert property (p_skip_miss) else $error("skip taken wrongly");
  a_io_clear: assert property (p_io_clear) else $error("io skip not taken");
  a_br_set: assert property (p_br_set) else $error("flag branch wrong");
  a_br_clr: assert property (p_br_clr) else $error("clear branch taken");
  a_br_c: assert property (p_br_c) else $error("carry branch wrong");
  a_br_eq: assert property (p_br_eq) else $error("equal branch wrong");
endmodule

bind csbu_core csbu_core_properties #(.PCW(PCW)) u_props (.clk(clk), .rst_n(rst_n), .ce(ce),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .reg_a(reg_a), .reg_b(reg_b), .imm(imm),
  .io_value(io_value), .bit_sel(bit_sel), .offset(offset), .next_two_words(next_two_words),
  .pc_in(pc_in), .status_in(status_in), .ready_ff(ready_ff), .done_ff(done_ff),
  .pc_load_ff(pc_load_ff), .pc_next_ff(pc_next_ff), .flags_we_ff(flags_we_ff),
  .status_ff(status_ff));

/* File: sim/test_compare_skip_branch_unit.sv */
/* Self-checking bench for csbu_core.
   Inputs change on the falling edge; one operand feeds reg_b, imm and io_value. */
`timescale 1ns/10ps
module test_compare_skip_branch_unit;
  import csbu_pkg::*;
  logic clk, rst_n, ce, cmd_valid, two, ready, done, ld, we;
  csbu_op_t op;
  logic [7:0] ra, v, st, so;
  logic [2:0] bs;
  logic [6:0] off;
  logic [15:0] pc, pn;
  int failures, samples_checked;
  always #5 clk = ~clk;
  csbu_core uut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(op),
    .reg_a(ra), .reg_b(v), .imm(v), .io_value(v), .bit_sel(bs), .offset(off),
    .next_two_words(two), .pc_in(pc), .status_in(st), .ready_ff(ready), .done_ff(done),
    .pc_load_ff(ld), .pc_next_ff(pn), .flags_we_ff(we), .status_ff(so));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One instruction: accept, wait for done, judge results
  task automatic run(input csbu_op_t o, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] s, input logic w, input int ne, input logic l,
      input logic [15:0] pe, input logic [7:0] se);
    int n;
    @(negedge clk);
    op = o; ra = a; v = b; bs = s; two = w; cmd_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("ready", 16'(ne == 1), 16'(ready));
    n = 1;
    while (done !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    if (n == 5) begin
      failures++;
      end_sim;
    end
    chk("cycles", 16'(ne), 16'(n));
    chk("ready", 16'h1, 16'(ready));
    chk("load", 16'(l), 16'(ld));
    chk("pc_next", pe, pn);
    chk("status", 16'(se), 16'(so));
    chk("flags_we", 16'(o == compare_immediate || o == compare_with_carry_in), 16'(we));
  endtask
  task t_reset;
    chk("ready", 16'h1, 16'(ready));
    chk("done", 16'h0, 16'(done));
    chk("load", 16'h0, 16'(ld));
    chk("flags_we", 16'h0, 16'(we));
    chk("pc_next", 16'h0, pn);
    chk("status", 16'h0, 16'(so));
    $display("reset test done");
  endtask
  task t_compare;
    st = 8'hd0;
    run(compare_immediate, 8'h10, 8'h10, 0, 0, 1, 0, 16'h0101, 8'hd2);
    run(compare_immediate, 8'h00, 8'h01, 0, 0, 1, 0, 16'h0101, 8'hf5);
    run(compare_immediate, 8'h80, 8'h01, 0, 0, 1, 0, 16'h0101, 8'hf8);
    st = 8'hd3;
    run(compare_with_carry_in, 8'h05, 8'h05, 0, 0, 1, 0, 16'h0101, 8'hf5);
    $display("compare test done");
  endtask
  task t_skip;
    st = 8'h5a;
    run(skip_reg_bit_clear, 0, 8'hfb, 2, 0, 2, 1, 16'h0102, 8'h5a);
    run(skip_reg_bit_clear, 0, 8'h04, 2, 1, 1, 0, 16'h0101, 8'h5a);
    run(skip_reg_bit_set, 0, 8'h04, 2, 1, 3, 1, 16'h0103, 8'h5a);
    run(skip_reg_bit_set, 0, 8'hfb, 2, 0, 1, 0, 16'h0101, 8'h5a);
    run(skip_io_bit_clear, 0, 8'h7f, 7, 0, 2, 1, 16'h0102, 8'h5a);
    run(skip_io_bit_clear, 0, 8'h80, 7, 1, 1, 0, 16'h0101, 8'h5a);
    run(skip_io_bit_set, 0, 8'h80, 7, 1, 3, 1, 16'h0103, 8'h5a);
    run(skip_io_bit_set, 0, 8'h7f, 7, 0, 1, 0, 16'h0101, 8'h5a);
    $display("skip test done");
  endtask
  task automatic t_branch;
    csbu_op_t o;
    logic [2:0] f;
    logic pol, tk;
    for (int i = 6; i < 16; i++) begin
      for (int j = 0; j < 2; j++) begin
        o = csbu_op_t'(i);
        st = j ? 8'h05 : 8'hfa;
        off = j ? 7'h3f : 7'h40;
        case (o)
          branch_equal, branch_not_equal: f = FLAG_Z;
          branch_negative, branch_positive: f = FLAG_N;
          branch_flag_set, branch_flag_clear: f = FLAG_V;
          default: f = FLAG_C;
        endcase
        pol = o inside {branch_flag_set, branch_equal, branch_carry_one, branch_lower,
          branch_negative};
        tk = st[f] == pol;
        run(o, 0, 0, f, 0, tk ? 2 : 1, tk, tk ? pc + {{9{off[6]}}, off} + 16'h1 : pc + 16'h1,
          st);
      end
    end
    $display("branch test done");
  endtask
  // Commands while ce is low must be ignored
  task t_ce;
    logic [15:0] old;
    @(negedge clk);
    old = pn;
    ce = 1'b0;
    op = branch_equal;
    st = 8'h02;
    cmd_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk("done", 16'h0, 16'(done));
    cmd_valid = 1'b0;
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk("pc_next", old, pn);
    $display("clock enable test done");
  endtask
  initial begin
    clk = 1'b0; rst_n = 1'b0; ce = 1'b1; cmd_valid = 1'b0; op = compare_immediate;
    ra = 8'h00; v = 8'h00; bs = 3'h0; off = 7'h00; two = 1'b0; pc = 16'h0100; st = 8'h00;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_compare;
    t_skip;
    t_branch;
    t_ce;
    end_sim;
  end
endmodule
